//--- rtl/hpx_host_port.sv
// hpx_host_port: pin-level host port with select, strobes, ready, irq
// assumes host pins are asynchronous; all but the mode and float pins pass two flops before use
`timescale 1ns/10ps
`default_nettype none
module hpx_host_port
  import hpx_pkg::*;
#(
  parameter int DATA_W = hpx_pkg::HPX_DATA_W,
  parameter int ADDR_W = hpx_pkg::HPX_ADDR_W
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic port_select_n, // host chip select, active low
  input wire logic transfer_strobe_first_n, // data strobe one, active low
  input wire logic transfer_strobe_second_n, // data strobe two, active low
  input wire logic transfer_direction, // 1 read, 0 write
  input wire logic addr_strobe_n, // address strobe, active low
  input wire logic access_select_0, // access select bit 0
  input wire logic access_select_1, // access select bit 1
  input wire logic ext_interface_select, // low: pins belong to host port
  input wire logic mux_mode_select, // low: multiplexed mode
  input wire logic output_float_n, // low: float all port outputs
  input wire logic port_reset_n, // host port reset, active low
  input wire logic [ADDR_W-1:0] hostAddr, // host address bus, direct in separate mode, latched by address strobe in multiplexed mode
  input wire logic [DATA_W-1:0] hostDataIn, // host data bus input
  output logic [DATA_W-1:0] hostDataOut, // host data bus output
  output logic hostDataOe, // host data bus output enable
  output logic port_ready_out, // ready pin level
  output logic port_ready_oe, // ready pin enable
  output logic subsys_a_host_irq_n, // subsystem a irq pin level
  output logic subsys_a_host_irq_oe, // subsystem a irq enable
  output logic subsys_b_host_irq_n, // subsystem b irq pin level
  output logic subsys_b_host_irq_oe, // subsystem b irq enable
  input wire logic subsysAIrqReq, // subsystem a raises host irq, pulse
  input wire logic subsysBIrqReq, // subsystem b raises host irq, pulse
  output logic subsysResetOut // resets both subsystems, level
);
  import hpx_pkg::*;

  // ********************************************
  // pin synchronisers
  // ********************************************
  localparam int SYNC_W = 9 + ADDR_W + DATA_W;
  logic [SYNC_W-1:0] syncMeta_r;
  logic [SYNC_W-1:0] syncPins_r;
  logic [SYNC_W-1:0] rawPins;
  assign rawPins = {port_select_n, transfer_strobe_first_n, transfer_strobe_second_n,
    transfer_direction, addr_strobe_n, access_select_0, access_select_1,
    ext_interface_select, port_reset_n, hostAddr, hostDataIn};
  // two flops on every host pin except the mode and float pins
  // bus words may skew by a cycle; the host holds them steady across the strobe
  always_ff @(posedge sys_clk) begin
    syncMeta_r <= rawPins;
    syncPins_r <= syncMeta_r;
  end

  logic selN, ds1N, ds2N, dirRd, asN, acc0, acc1, extSel, prstN;
  logic [ADDR_W-1:0] sAddr;
  logic [DATA_W-1:0] sData;
  assign {selN, ds1N, ds2N, dirRd, asN, acc0, acc1, extSel, prstN, sAddr, sData} = syncPins_r;

  // ********************************************
  // mode and strobe decode
  // ********************************************
  logic portOwned, muxMode, portReset, strobeAct, selAct, xferAct;
  logic [1:0] accSel;
  assign portOwned = !extSel;
  // mode pin is a board strap read directly; change it only while idle
  assign muxMode = !mux_mode_select;
  assign portReset = reset || !prstN;
  // combined strobe: active when either strobe low
  assign strobeAct = !(ds1N && ds2N);
  assign selAct = portOwned && !selN;
  assign xferAct = selAct && strobeAct;
  assign accSel = muxMode ? {acc1, acc0} : HPX_SEL_DATA;
  assign subsysResetOut = portReset;

  // ********************************************
  // transfer state machine
  // ********************************************
  hpx_state_type state_r, state_nxt;
  logic [1:0] accCnt_r, accCnt_nxt;
  logic xferStart, accDone;
  assign xferStart = (state_r == HPX_IDLE) && xferAct;
  assign accDone = (accCnt_r == 2'h0);

  // next state: wait for strobe release before next transfer
  always_comb begin
    state_nxt = state_r;
    accCnt_nxt = accCnt_r;
    case (state_r)
      HPX_IDLE: begin
        if (xferAct) begin
          state_nxt = HPX_BUSY;
          accCnt_nxt = HPX_ACC_CNT_W1;
        end
      end
      HPX_BUSY: begin
        if (accDone) begin
          state_nxt = HPX_HOLD;
        end else begin
          accCnt_nxt = accCnt_r - 2'h1;
        end
      end
      HPX_HOLD: begin
        if (!strobeAct) begin
          state_nxt = HPX_DONE;
        end
      end
      HPX_DONE: begin
        state_nxt = HPX_IDLE; // select may stay low
      end
      default: begin
        state_nxt = HPX_IDLE;
      end
    endcase
  end

  // state and access counter registers
  always_ff @(posedge sys_clk) begin
    if (portReset) begin
      state_r <= HPX_IDLE;
      accCnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      accCnt_r <= accCnt_nxt;
    end
  end

  // ********************************************
  // transfer latch and register access
  // ********************************************
  logic isRead_r, isRead_nxt;
  logic [1:0] accLat_r, accLat_nxt;
  logic [DATA_W-1:0] wrLat_r, wrLat_nxt;
  logic [ADDR_W-1:0] addrSep_r, addrSep_nxt;
  assign isRead_nxt = xferStart ? dirRd : isRead_r;
  assign accLat_nxt = xferStart ? accSel : accLat_r;
  assign wrLat_nxt = xferStart ? sData : wrLat_r;
  assign addrSep_nxt = xferStart ? sAddr : addrSep_r;
  // hold the transfer fields for the whole access
  always_ff @(posedge sys_clk) begin
    if (portReset) begin
      isRead_r <= 1'h0;
      accLat_r <= HPX_SEL_CTRL;
      wrLat_r <= HPX_DATA_RESET;
      addrSep_r <= HPX_ADDR_RESET;
    end else begin
      isRead_r <= isRead_nxt;
      accLat_r <= accLat_nxt;
      wrLat_r <= wrLat_nxt;
      addrSep_r <= addrSep_nxt;
    end
  end

  // data codes with or without post-increment
  function automatic logic isDataSel(input logic [1:0] code);
    return (code == HPX_SEL_DATA) || (code == HPX_SEL_DATA_INC);
  endfunction : isDataSel

  // one action pulse at the first busy cycle
  logic actPulse, doWrite, doRead, wrCtl, wrAddr, wrDat, rdDat, incAddr;
  assign actPulse = (state_r == HPX_BUSY) && (accCnt_r == HPX_ACC_CNT_W1);
  assign doWrite = actPulse && !isRead_r;
  assign doRead = actPulse && isRead_r;
  assign wrCtl = doWrite && (accLat_r == HPX_SEL_CTRL);
  assign wrAddr = doWrite && (accLat_r == HPX_SEL_ADDR);
  assign wrDat = doWrite && isDataSel(accLat_r);
  assign rdDat = doRead && isDataSel(accLat_r);
  assign incAddr = actPulse && (accLat_r == HPX_SEL_DATA_INC);

  // address register: latched by address strobe or written by the host
  logic [ADDR_W-1:0] portAddr_r, portAddr_nxt;
  logic asLatch, asPrev_r;
  assign asLatch = muxMode && selAct && !asN && asPrev_r;
  always_comb begin
    portAddr_nxt = portAddr_r;
    if (asLatch) begin
      portAddr_nxt = sAddr;
    end else if (wrAddr) begin
      portAddr_nxt = ADDR_W'(wrLat_r);
    end else if (incAddr) begin
      portAddr_nxt = portAddr_r + ADDR_W'(1);
    end
  end
  // address register and address strobe history, idle high after reset
  always_ff @(posedge sys_clk) begin
    if (portReset) begin
      portAddr_r <= HPX_ADDR_RESET;
      asPrev_r <= 1'h1;
    end else begin
      portAddr_r <= portAddr_nxt;
      asPrev_r <= asN;
    end
  end

  // ********************************************
  // control register and host interrupts
  // ********************************************
  logic irqA_r, irqB_r, irqA_nxt, irqB_nxt, clrA, clrB;
  logic [DATA_W-1:0] ctlOther_r, ctlOther_nxt;
  assign clrA = wrCtl && wrLat_r[HPX_CTL_IRQ_A_BIT];
  assign clrB = wrCtl && wrLat_r[HPX_CTL_IRQ_B_BIT];
  // set wins over clear; no irqs in separate-bus mode
  assign irqA_nxt = muxMode && (subsysAIrqReq || (irqA_r && !clrA));
  assign irqB_nxt = muxMode && (subsysBIrqReq || (irqB_r && !clrB));
  assign ctlOther_nxt = wrCtl ? wrLat_r : ctlOther_r;
  always_ff @(posedge sys_clk) begin
    if (portReset) begin
      irqA_r <= 1'h0;
      irqB_r <= 1'h0;
      ctlOther_r <= HPX_CTL_RESET;
    end else begin
      irqA_r <= irqA_nxt;
      irqB_r <= irqB_nxt;
      ctlOther_r <= ctlOther_nxt;
    end
  end
  // irq bits read back live; the rest echo the last control write
  logic [DATA_W-1:0] ctlView;
  always_comb begin
    ctlView = ctlOther_r;
    ctlView[HPX_CTL_IRQ_A_BIT] = irqA_r;
    ctlView[HPX_CTL_IRQ_B_BIT] = irqB_r;
  end

  // ********************************************
  // memory and read data
  // ********************************************
  logic [ADDR_W-1:0] memAddrFull;
  logic [DATA_W-1:0] memRd;
  assign memAddrFull = muxMode ? portAddr_r : addrSep_r;
  // only the low address bits reach the memory; upper bits wrap
  hpx_mem #(
    .DATA_W(DATA_W),
    .DEPTH(HPX_MEM_DEPTH),
    .AW(HPX_MEM_AW)
  ) hpx_mem_inst (
    .sys_clk(sys_clk),
    .wrEn(wrDat),
    .addr(memAddrFull[HPX_MEM_AW-1:0]),
    .wrData(wrLat_r),
    .rdData(memRd)
  );

  logic rdDatD_r;
  logic [DATA_W-1:0] rdOut_r, rdOut_nxt;
  // capture read value once memory data is valid
  always_comb begin
    rdOut_nxt = rdOut_r;
    if (rdDatD_r) begin
      rdOut_nxt = memRd;
    end else if (doRead && accLat_r == HPX_SEL_CTRL) begin
      rdOut_nxt = ctlView;
    end else if (doRead && accLat_r == HPX_SEL_ADDR) begin
      rdOut_nxt = DATA_W'(portAddr_r);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (portReset) begin
      rdDatD_r <= 1'h0;
      rdOut_r <= HPX_DATA_RESET;
    end else begin
      rdDatD_r <= rdDat;
      rdOut_r <= rdOut_nxt;
    end
  end

  // ********************************************
  // pin drivers
  // ********************************************
  // float acts without sync so the pins let go at once
  logic pinsOn;
  assign pinsOn = output_float_n && portOwned;
  assign hostDataOut = rdOut_r;
  assign hostDataOe = pinsOn && selAct && isRead_r && (state_r == HPX_HOLD);
  // ready high when idle or data held; low while access runs
  assign port_ready_out = (state_r != HPX_BUSY);
  assign port_ready_oe = pinsOn;
  // irq pins are active low; enables drop in separate-bus mode
  assign subsys_a_host_irq_n = !irqA_r;
  assign subsys_b_host_irq_n = !irqB_r;
  assign subsys_a_host_irq_oe = pinsOn && muxMode;
  assign subsys_b_host_irq_oe = pinsOn && muxMode;
endmodule : hpx_host_port
`default_nettype wire

//--- rtl/hpx_mem.sv
// hpx_mem: small shared word memory reached by the host port
// assumes one clock; read data is registered one cycle after the request
`timescale 1ns/10ps
`default_nettype none
module hpx_mem #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic sys_clk, // system clock
  input wire logic wrEn, // write strobe
  input wire logic [AW-1:0] addr, // word address
  input wire logic [DATA_W-1:0] wrData, // write data
  output logic [DATA_W-1:0] rdData // registered read data
);
  logic [DATA_W-1:0] memArray [DEPTH];
  // write and registered read
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      memArray[addr] <= wrData;
    end
    rdData <= memArray[addr];
  end
endmodule : hpx_mem
`default_nettype wire

//--- rtl/hpx_pkg.sv
// hpx_pkg: constants and types for the host port pin handshake block
// assumes a single 250 MHz system clock and synchronous reset
package hpx_pkg;
  localparam int HPX_DATA_W = 16;
  localparam int HPX_ADDR_W = 18;
  localparam int HPX_MEM_DEPTH = 256;
  localparam int HPX_MEM_AW = 8;
  // access select codes: control, data with post-increment, address, data
  localparam logic [1:0] HPX_SEL_CTRL = 2'h0;
  localparam logic [1:0] HPX_SEL_DATA_INC = 2'h1;
  localparam logic [1:0] HPX_SEL_ADDR = 2'h2;
  localparam logic [1:0] HPX_SEL_DATA = 2'h3;
  // control register field positions
  localparam int HPX_CTL_IRQ_A_BIT = 2;
  localparam int HPX_CTL_IRQ_B_BIT = 3;
  localparam logic [15:0] HPX_CTL_RESET = 16'h0000;
  localparam logic [17:0] HPX_ADDR_RESET = 18'h0_0000;
  localparam logic [15:0] HPX_DATA_RESET = 16'h0000;
  // memory access latency in ns and derived cycles at 4 ns period
  localparam int HPX_CLK_NS = 4;
  localparam int HPX_ACCESS_NS = 8;
  localparam int HPX_ACCESS_CYC = (HPX_ACCESS_NS + HPX_CLK_NS - 1) / HPX_CLK_NS;
  localparam logic [1:0] HPX_ACC_CNT_W1 = 2'(HPX_ACCESS_CYC);
  typedef enum logic [3:0] {
    HPX_IDLE = 4'b0001,
    HPX_BUSY = 4'b0010,
    HPX_HOLD = 4'b0100,
    HPX_DONE = 4'b1000
  } hpx_state_type;
endpackage : hpx_pkg

//--- testbench/hpx_host_model.sv
// hpx_host_model: external host processor driving the port pins
// assumes the bench calls xfer and astb; pins change at falling edges
`timescale 1ns/10ps
`default_nettype none
module hpx_host_model (
  input wire logic sys_clk, // clock
  input wire logic rdy, // ready pin
  input wire logic [15:0] dOut, // read data
  input wire logic dOe, // data bus enable
  output logic selN, // select
  output logic s1N, // strobe one
  output logic s2N, // strobe two
  output logic dir, // direction
  output logic asN, // address strobe
  output logic [1:0] acc, // access select
  output logic [17:0] addr, // address bus
  output logic [15:0] dIn // write data
);
  // ******************************
  // host bus cycles
  // ******************************
  initial {selN, s1N, s2N, dir, asN, acc, addr, dIn} = '1;
  // one transfer; select stays low afterwards
  task automatic xfer(input logic [1:0] c, input logic r, input logic [15:0] d,
      input logic [17:0] a, input int slow, output logic [15:0] q);
    int n;
    n = 0;
    @(negedge sys_clk);
    selN = 1'h0;
    {dir, acc, dIn, addr} = {r, c, d, a};
    if (slow[0]) s2N = 1'h0; else s1N = 1'h0;
    while (rdy === 1'h1 && n < 12) begin @(negedge sys_clk); n++; end
    while (rdy !== 1'h1 && n < 30) begin @(negedge sys_clk); n++; end
    repeat (2 + slow) @(negedge sys_clk);
    q = dOe ? dOut : ~dOut; // undriven bus reads as inverse
    {s1N, s2N, dIn, addr} = {2'h3, ~d, ~a}; // released lines flip
    repeat (3) @(negedge sys_clk);
  endtask : xfer
  // latch an address with the address strobe
  task automatic astb(input logic [17:0] a);
    @(negedge sys_clk);
    {addr, asN} = {a, 1'h0};
    repeat (4) @(negedge sys_clk);
    {addr, asN} = {~a, 1'h1};
    repeat (2) @(negedge sys_clk);
  endtask : astb
endmodule : hpx_host_model
`default_nettype wire

//--- testbench/hpx_host_port_asserts.sv
// hpx_host_port_asserts: pin-level checks on the host port outputs
// assumes it is bound onto every hpx_host_port instance, one clock
`timescale 1ns/10ps
`default_nettype none
module hpx_host_port_asserts (
  input wire logic sys_clk, // clock
  input wire logic reset, // sync reset
  input wire logic port_reset_n, // port reset pin
  input wire logic transfer_strobe_first_n, // strobe one
  input wire logic transfer_strobe_second_n, // strobe two
  input wire logic transfer_direction, // 1 read
  input wire logic ext_interface_select, // pin owner
  input wire logic mux_mode_select, // mode strap
  input wire logic output_float_n, // float pin
  input wire logic subsysAIrqReq, // irq request a
  input wire logic hostDataOe, // data enable
  input wire logic port_ready_out, // ready level
  input wire logic port_ready_oe, // ready enable
  input wire logic subsys_a_host_irq_n, // irq a level
  input wire logic subsys_a_host_irq_oe, // irq a enable
  input wire logic subsys_b_host_irq_n, // irq b level
  input wire logic subsys_b_host_irq_oe, // irq b enable
  input wire logic subsysResetOut // subsystem reset
);
  // ******************************
  // properties on the port pins
  // ******************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_float_ready_oe: assert property (!output_float_n |-> !port_ready_oe)
    else $error("ready pin driven while floating");
  a_float_irq_oe: assert property (
    !output_float_n |-> !(subsys_a_host_irq_oe || subsys_b_host_irq_oe))
    else $error("irq pin driven while floating");
  a_float_data_oe: assert property (!output_float_n |-> !hostDataOe)
    else $error("data bus driven while floating");
  a_ready_busy_len: assert property (
    $fell(port_ready_out) |-> !port_ready_out[*3] ##1 port_ready_out)
    else $error("ready low for wrong length");
  a_irq_req_sets: assert property (
    !mux_mode_select && port_reset_n && subsysAIrqReq |-> ##[1:2] !subsys_a_host_irq_n)
    else $error("irq request did not assert pin");
  a_sep_no_irq: assert property (
    mux_mode_select && $past(mux_mode_select) |-> subsys_a_host_irq_n && subsys_b_host_irq_n)
    else $error("irq asserted in separate mode");
  a_ext_no_take: assert property (ext_interface_select[*8] |-> port_ready_out)
    else $error("transfer taken while pins owned elsewhere");
  a_port_rst_sub: assert property (!port_reset_n[*3] |-> subsysResetOut)
    else $error("port reset did not reset subsystems");
  a_idle_no_drive: assert property (
    (transfer_strobe_first_n && transfer_strobe_second_n)[*4] |-> !hostDataOe)
    else $error("data driven with strobes idle");
  a_write_no_drive: assert property (!transfer_direction[*8] |-> !hostDataOe)
    else $error("data driven during write");
  // main scenarios
  cover property ($fell(port_ready_out));
  cover property ($fell(subsys_a_host_irq_n));
  cover property ($rose(hostDataOe));
endmodule : hpx_host_port_asserts
bind hpx_host_port hpx_host_port_asserts hpx_host_port_asserts_inst (.sys_clk, .reset,
  .port_reset_n, .transfer_strobe_first_n, .transfer_strobe_second_n, .transfer_direction,
  .ext_interface_select, .mux_mode_select, .output_float_n, .subsysAIrqReq, .hostDataOe,
  .port_ready_out, .port_ready_oe, .subsys_a_host_irq_n, .subsys_a_host_irq_oe,
  .subsys_b_host_irq_n, .subsys_b_host_irq_oe, .subsysResetOut);
`default_nettype wire

//--- testbench/hpx_host_port_bench.sv
// hpx_host_port_bench: self-checking bench for hpx_host_port
// assumes hpx_host_model as the host and the bound checker
`timescale 1ns/10ps
`default_nettype none
module hpx_host_port_bench;
  import hpx_pkg::*;
  logic sys_clk = 1'h0, reset = 1'h1, extSel = 1'h0, muxMode = 1'h0, floatN = 1'h1;
  logic prstN = 1'h1, irqA = 1'h0, irqB = 1'h0;
  logic selN, s1N, s2N, dir, asN, dOe, rdy, rdyOe, aN, aOe, bN, bOe, subRst;
  logic [1:0] acc;
  logic [17:0] addr;
  logic [15:0] dIn, dOut, q, d;
  int badCount = 0, samplesChecked = 0, cyc = 0, i, ptr;
  int mem [256];
  // ******************************
  // clock, instances, checks
  // ******************************
  always #2 sys_clk = ~sys_clk;
  hpx_host_port hpx_host_port_inst (.sys_clk, .reset, .port_select_n(selN),
    .transfer_strobe_first_n(s1N), .transfer_strobe_second_n(s2N), .transfer_direction(dir),
    .addr_strobe_n(asN), .access_select_0(acc[0]), .access_select_1(acc[1]),
    .ext_interface_select(extSel), .mux_mode_select(muxMode), .output_float_n(floatN),
    .port_reset_n(prstN), .hostAddr(addr), .hostDataIn(dIn), .hostDataOut(dOut),
    .hostDataOe(dOe), .port_ready_out(rdy), .port_ready_oe(rdyOe), .subsys_a_host_irq_n(aN),
    .subsys_a_host_irq_oe(aOe), .subsys_b_host_irq_n(bN), .subsys_b_host_irq_oe(bOe),
    .subsysAIrqReq(irqA), .subsysBIrqReq(irqB), .subsysResetOut(subRst));
  hpx_host_model host_inst (.sys_clk, .rdy, .dOut, .dOe, .selN, .s1N, .s2N, .dir, .asN,
    .acc, .addr, .dIn);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("Error at %0t expected %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic results;
    $display("checked %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin badCount++; results; end
  end
  // test sequence
  initial begin
    void'($urandom(20));
    repeat (10) @(negedge sys_clk);
    chk(16'({rdy, aN, bN, dOe, subRst}), 16'h001d);
    reset = 1'h0;
    @(negedge sys_clk);
    ptr = $urandom_range(200);
    host_inst.xfer(HPX_SEL_ADDR, 1'h0, 16'(ptr), '0, 0, q);
    for (i = 0; i < 8; i++) begin
      mem[ptr+i] = $urandom & 16'hffff;
      host_inst.xfer(HPX_SEL_DATA_INC, 1'h0, 16'(mem[ptr+i]), '0, i % 3, q);
    end
    host_inst.xfer(HPX_SEL_ADDR, 1'h0, 16'(ptr), '0, 1, q);
    for (i = 0; i < 8; i++) begin
      host_inst.xfer(HPX_SEL_DATA_INC, 1'h1, '0, '0, i % 3, q);
      chk(q, 16'(mem[ptr+i]));
    end
    d = 16'($urandom);
    host_inst.xfer(HPX_SEL_DATA, 1'h0, d, '0, 0, q);
    for (i = 0; i < 2; i++) begin
      host_inst.xfer(HPX_SEL_DATA, 1'h1, '0, '0, 0, q);
      chk(q, d);
    end
    $display("burst test done");
    host_inst.astb(18'(ptr + 3));
    host_inst.xfer(HPX_SEL_DATA, 1'h1, '0, '0, 0, q);
    chk(q, 16'(mem[ptr+3]));
    host_inst.xfer(HPX_SEL_ADDR, 1'h1, '0, '0, 0, q);
    chk(q, 16'(ptr + 3));
    $display("address strobe test done");
    {irqA, irqB} = 2'h3;
    @(negedge sys_clk);
    {irqA, irqB} = 2'h0;
    repeat (3) @(negedge sys_clk);
    chk(16'({aN, bN, aOe, bOe}), 16'h0003);
    host_inst.xfer(HPX_SEL_CTRL, 1'h1, '0, '0, 0, q);
    chk(q, HPX_CTL_RESET | 16'((1 << HPX_CTL_IRQ_A_BIT) | (1 << HPX_CTL_IRQ_B_BIT)));
    host_inst.xfer(HPX_SEL_CTRL, 1'h0, 16'(1 << HPX_CTL_IRQ_A_BIT), '0, 0, q);
    chk(16'({aN, bN}), 16'h0002);
    host_inst.xfer(HPX_SEL_CTRL, 1'h0, 16'(1 << HPX_CTL_IRQ_B_BIT), '0, 0, q);
    chk(16'({aN, bN}), 16'h0003);
    $display("irq test done");
    extSel = 1'h1;
    host_inst.xfer(HPX_SEL_DATA, 1'h0, ~d, '0, 0, q);
    chk(16'(rdy), 16'h0001);
    extSel = 1'h0;
    host_inst.xfer(HPX_SEL_DATA, 1'h1, '0, '0, 0, q);
    chk(q, 16'(mem[ptr+3]));
    $display("pin owner test done");
    floatN = 1'h0;
    @(negedge sys_clk);
    chk(16'({rdyOe, aOe, bOe, dOe}), 16'h0000);
    floatN = 1'h1;
    $display("float test done");
    muxMode = 1'h1;
    repeat (3) @(negedge sys_clk);
    irqA = 1'h1;
    @(negedge sys_clk);
    irqA = 1'h0;
    repeat (3) @(negedge sys_clk);
    chk(16'({aN, aOe}), 16'h0002);
    d = 16'($urandom);
    host_inst.xfer(HPX_SEL_CTRL, 1'h0, d, 18'(ptr + 9), 0, q);
    muxMode = 1'h0;
    repeat (3) @(negedge sys_clk);
    host_inst.astb(18'(ptr + 9));
    host_inst.xfer(HPX_SEL_DATA, 1'h1, '0, '0, 0, q);
    chk(q, d);
    $display("mode test done");
    prstN = 1'h0;
    repeat (3) @(negedge sys_clk);
    chk(16'(subRst), 16'h0001);
    prstN = 1'h1;
    repeat (4) @(negedge sys_clk);
    chk(16'(subRst), 16'h0000);
    $display("port reset test done");
    results;
  end
endmodule : hpx_host_port_bench
`default_nettype wire
